// >>> design/sysconf_bank.sv
`timescale 1ns/1ps

// Operation
// - pull-up and low-drive per port, documented resets
// - mode pads pulled down during external reset
// - read-only 16-bit part identification value
// - identification bytes at offsets 1A and 1B
// - family codes in bits 15-12, 11-8
// - major mask revision in bits 7-4
// - minor revision bits 3-0, not for identification
// - memory map straps tied to fixed values
// - straps readable at offsets 1C and 1D
// - module clocks gated by mode and bits
// - stop mode halts all module clocks
// - core clocked in wait unless system wait clock stop is set; peripherals per bit, except the voltage monitor, which is off
// - module wait gating only when system clocks run
// - block base from five upper address bits
// - pull-up register bits 7, 4, 1, 0
module sysconf_bank
  import sysconf_pkg::*;
#(
  // arbitrary identification code
  parameter logic [3:0] MAJOR_FAMILY = 4'h1,
  parameter logic [3:0] MINOR_FAMILY = 4'h2,
  parameter logic [3:0] MAJOR_REV    = 4'h3,
  parameter logic [3:0] MINOR_REV    = 4'h4
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // external reset pin level
  input  wire logic        ext_reset_n,
  // peripheral bus
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [7:0]  bus_wdata,
  output logic             bus_hit,
  output logic [7:0]       bus_rdata_q,
  // operating mode and module configuration bits
  input  wire op_mode_t    mode,
  input  wire clk_cfg_t    clk_cfg,
  // pad control
  output pad_ctl_t         pad_ctl_q,
  // register block base, bits 15:11
  output logic [4:0]       regblock_base_q,
  // gated clock enables
  output clk_en_t          clk_en_q
);

  // ****************************************************************
  // identification and strap constants
  // ****************************************************************
  logic [3:0]  major_family;
  logic [3:0]  minor_family;
  logic [3:0]  major_rev;
  logic [3:0]  minor_rev;
  logic [15:0] part_ident;
  logic [7:0]  part_ident_high;
  logic [7:0]  part_ident_low;

  // the four identification fields, each fixed at build time
  assign major_family = MAJOR_FAMILY;
  assign minor_family = MINOR_FAMILY;
  assign major_rev    = MAJOR_REV;
  // may move between mask sets, so software must not key on it
  assign minor_rev    = MINOR_REV;

  // fields packed by position, so a field edit cannot shift others
  assign part_ident = (16'(major_family) << ID_MAJOR_FAM_LSB)
                    | (16'(minor_family) << ID_MINOR_FAM_LSB)
                    | (16'(major_rev) << ID_MAJOR_REV_LSB)
                    | (16'(minor_rev) << ID_MINOR_REV_LSB);

  // byte halves in the order the bus reads them
  assign part_ident_high = part_ident[15:8];
  assign part_ident_low  = part_ident[7:0];

  logic       regblock_size_strap;
  logic [2:0] sram_size_strap;
  logic [1:0] cal_ram_size_strap;
  logic [1:0] rom_map_strap;
  logic [1:0] paging_space_strap;
  logic [7:0] memsize_0;
  logic [7:0] memsize_1;

  // memory map straps are wired constants; nothing can overwrite them
  assign regblock_size_strap = REGBLOCK_SIZE_STRAP;
  assign sram_size_strap     = SRAM_SIZE_STRAP;
  assign cal_ram_size_strap  = CAL_RAM_SIZE_STRAP;
  assign rom_map_strap       = ROM_MAP_STRAP;
  assign paging_space_strap  = PAGING_SPACE_STRAP;

  // read-back images; gaps between fields read as zero
  assign memsize_0 = {regblock_size_strap, 1'b0,
                      cal_ram_size_strap, 1'b0,
                      sram_size_strap};
  assign memsize_1 = {rom_map_strap, 4'h0,
                      paging_space_strap};

  // ****************************************************************
  // address decode
  // ****************************************************************
  logic [7:0] base_init_q;
  logic [3:0] regblock_base_init;
  logic [4:0] base_hi;
  logic [9:0] ofs;
  logic       in_block;

  // only bits 6:3 of the init register carry address bits 14:11
  assign regblock_base_init = base_init_q[BASE_LSB +: 4];
  // top bit is always zero: block lives in the first 32K;
  // the block spans 1K of its 2K slot, the upper half stays silent
  assign base_hi  = {1'b0, regblock_base_init};
  assign in_block = (bus_addr[15:11] == base_hi)
                  & ~bus_addr[10];  // 1K block
  assign ofs      = bus_addr[9:0];

  logic sel_pull;
  logic sel_drive;
  logic sel_base;
  logic sel_id_hi;
  logic sel_id_lo;
  logic sel_ms0;
  logic sel_ms1;

  // one select per implemented register
  always_comb begin
    sel_pull  = in_block & (ofs == OFS_PULL_ENABLE);
    sel_drive = in_block & (ofs == OFS_REDUCED_DRIVE);
    sel_base  = in_block & (ofs == OFS_BASE_INIT);
    sel_id_hi = in_block & (ofs == OFS_IDENT_HIGH);
    sel_id_lo = in_block & (ofs == OFS_IDENT_LOW);
    sel_ms0   = in_block & (ofs == OFS_MEMSIZE_0);
    sel_ms1   = in_block & (ofs == OFS_MEMSIZE_1);
  end

  logic any_sel;
  logic rd_en;
  logic wr_en;

  // any implemented register of this bank
  assign any_sel = sel_pull | sel_drive | sel_base
                 | sel_id_hi | sel_id_lo
                 | sel_ms0 | sel_ms1;

  // qualified strobes; writes to read-only registers are taken and dropped
  assign rd_en = bus_rd & any_sel;
  assign wr_en = bus_wr & any_sel;

  // hit tells the bus fabric that this bank answers the access
  assign bus_hit = rd_en | wr_en;

  // ****************************************************************
  // writable registers
  // ****************************************************************
  logic [7:0] pull_q;
  logic [7:0] pull_d;
  logic [7:0] drive_q;
  logic [7:0] drive_d;
  logic [7:0] base_init_d;
  logic       wr_pull;
  logic       wr_drive;
  logic       wr_base;

  // one write strobe per writable register
  assign wr_pull  = wr_en & sel_pull;
  assign wr_drive = wr_en & sel_drive;
  assign wr_base  = wr_en & sel_base;

  // pull-up next value: only the documented bits store
  always_comb begin
    pull_d = pull_q;
    if (wr_pull) begin
      pull_d = bus_wdata & PAD_REG_MASK;
    end
  end

  // drive next value: same four bit positions as the pull-ups
  always_comb begin
    drive_d = drive_q;
    if (wr_drive) begin
      drive_d = bus_wdata & PAD_REG_MASK;
    end
  end

  // base next value: bit 7 masked so the block stays below 32K
  always_comb begin
    base_init_d = base_init_q;
    if (wr_base) begin
      base_init_d = bus_wdata & BASE_INIT_MASK;
    end
  end

  // pull-up enables: bus-control and emulation on at reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pull_q <= PULL_RESET;
    end else begin
      pull_q <= pull_d;
    end
  end

  // drive strength: full drive everywhere at reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      drive_q <= DRIVE_RESET;
    end else begin
      drive_q <= drive_d;
    end
  end

  // block base; moving it takes effect on the next access
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_init_q <= BASE_RESET;
    end else begin
      base_init_q <= base_init_d;
    end
  end

  assign regblock_base_q = base_hi;

  // ****************************************************************
  // read-back
  // ****************************************************************
  logic [7:0] pull_enable_control;
  logic [7:0] reduced_drive_control;
  logic [7:0] rdata_d;

  // register images as the bus reads them; stored bits are pre-masked
  assign pull_enable_control   = pull_q;
  assign reduced_drive_control = drive_q;

  // identification and size registers ignore writes: no store exists
  always_comb begin
    rdata_d = 8'h00;
    if (bus_rd) begin
      unique case (1'b1)
        sel_pull:  rdata_d = pull_enable_control;
        sel_drive: rdata_d = reduced_drive_control;
        sel_base:  rdata_d = base_init_q;
        sel_id_hi: rdata_d = part_ident_high;
        sel_id_lo: rdata_d = part_ident_low;
        sel_ms0:   rdata_d = memsize_0;
        sel_ms1:   rdata_d = memsize_1;
        default:   rdata_d = 8'h00;
      endcase
    end
  end

  // read data lands one cycle after the strobe and holds; an unmapped
  // read still loads zero, so stale data never looks like an answer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_rdata_q <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // pad control outputs
  // ****************************************************************
  logic [NUM_PADS-1:0] pullup_d;
  logic [NUM_PADS-1:0] low_drive_d;
  logic [NUM_PADS-1:0] pullup_rst;
  logic [NUM_PADS-1:0] low_drive_rst;
  logic [NUM_PADS-1:0] pullup_en_q;
  logic [NUM_PADS-1:0] low_drive_q;
  logic                mode_pulldown_q;

  // map each pad group to its register bit, reset image included
  for (genvar gi = 0; gi < NUM_PADS; gi++) begin : g_pad
    assign pullup_d[gi]      = pull_d[PAD_BIT_POS[gi]];
    assign low_drive_d[gi]   = drive_d[PAD_BIT_POS[gi]];
    assign pullup_rst[gi]    = PULL_RESET[PAD_BIT_POS[gi]];
    assign low_drive_rst[gi] = DRIVE_RESET[PAD_BIT_POS[gi]];
  end

  // pull-ups follow the register next state, so the pads switch
  // at the same edge as the register does
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pullup_en_q <= pullup_rst;
    end else begin
      pullup_en_q <= pullup_d;
    end
  end

  // reduced drive, same timing as the pull-ups
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_drive_q <= low_drive_rst;
    end else begin
      low_drive_q <= low_drive_d;
    end
  end

  // mode-pad pull-down follows the pin, not the internal reset,
  // and has no software control at all
  always_ff @(posedge clk_sys) begin
    mode_pulldown_q <= ~ext_reset_n;
  end

  // one flop per concern, gathered into the pad bundle
  assign pad_ctl_q = '{pullup_en:     pullup_en_q,
                       low_drive:     low_drive_q,
                       mode_pulldown: mode_pulldown_q};

  // ****************************************************************
  // module clock gating
  // ****************************************************************
  // the policy registers its enables, so a mode change reaches the
  // gates one cycle later; this keeps the gate enables glitch-free
  clk_gate_policy u_clk_gate (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .mode     (mode),
    .cfg      (clk_cfg),
    .clk_en_q (clk_en_q)
  );

endmodule : sysconf_bank

// >>> design/sysconf_pkg.sv
package sysconf_pkg;

  // ****************************************************************
  // register offsets within the 1K register block
  // ****************************************************************
  localparam logic [9:0] OFS_PULL_ENABLE   = 10'h00c;
  localparam logic [9:0] OFS_REDUCED_DRIVE = 10'h00d;
  localparam logic [9:0] OFS_BASE_INIT     = 10'h011;
  localparam logic [9:0] OFS_IDENT_HIGH    = 10'h01a;
  localparam logic [9:0] OFS_IDENT_LOW     = 10'h01b;
  localparam logic [9:0] OFS_MEMSIZE_0     = 10'h01c;
  localparam logic [9:0] OFS_MEMSIZE_1     = 10'h01d;

  // ****************************************************************
  // field layout and reset values
  // ****************************************************************
  localparam int unsigned NUM_PADS       = 4;
  localparam int unsigned PAD_ADDR       = 0;
  localparam int unsigned PAD_DATA       = 1;
  localparam int unsigned PAD_BUSCTL     = 2;
  localparam int unsigned PAD_EMUL       = 3;
  // register bit of each pad group, indexed by PAD_*
  localparam int unsigned PAD_BIT_POS [NUM_PADS] = '{0, 1, 4, 7};
  localparam logic [7:0]  PAD_REG_MASK   = 8'h93;
  localparam logic [7:0]  PULL_RESET     = 8'h90;
  localparam logic [7:0]  DRIVE_RESET    = 8'h00;
  localparam logic [7:0]  BASE_INIT_MASK = 8'h78;
  localparam logic [7:0]  BASE_RESET     = 8'h00;
  localparam int unsigned BASE_LSB       = 3;   // base bits 14:11 in reg bits 6:3

  // identification fields
  localparam int unsigned ID_MAJOR_FAM_LSB = 12;
  localparam int unsigned ID_MINOR_FAM_LSB = 8;
  localparam int unsigned ID_MAJOR_REV_LSB = 4;
  localparam int unsigned ID_MINOR_REV_LSB = 0;

  // memory map straps, tied
  localparam logic       REGBLOCK_SIZE_STRAP = 1'b0;
  localparam logic [2:0] SRAM_SIZE_STRAP     = 3'h0;
  localparam logic [1:0] CAL_RAM_SIZE_STRAP  = 2'h1;
  localparam logic [1:0] ROM_MAP_STRAP       = 2'h3;
  localparam logic [1:0] PAGING_SPACE_STRAP  = 2'h3;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_WAIT,
    MODE_STOP
  } op_mode_t;

  // per-module wait-disable and run-enable bits
  typedef struct packed {
    logic system_wait_clock_stop;
    logic pulse_mod_wait_stop;
    logic capture_timer_wait_stop;
    logic converter_wait_stop;
    logic serial_periph_wait_stop;
    logic async_serial_wait_stop;
    logic serial_periph_run_en;
    logic volt_monitor_en;
  } clk_cfg_t;

  // clock enables for each gated module clock
  typedef struct packed {
    logic core;
    logic flash;
    logic cal_ram;
    logic sram;
    logic port_int;
    logic pulse_mod;
    logic capture_timer;
    logic converter;
    logic serial_periph;
    logic volt_monitor;
    logic async_serial;
  } clk_en_t;

  typedef struct packed {
    logic [NUM_PADS-1:0] pullup_en;
    logic [NUM_PADS-1:0] low_drive;
    logic                mode_pulldown;
  } pad_ctl_t;

endpackage : sysconf_pkg

// >>> design/clk_gate_policy.sv
`timescale 1ns/1ps

module clk_gate_policy
  import sysconf_pkg::*;
(
  // clock and reset
  input  wire logic     clk_sys,
  input  wire logic     rst,
  // mode and configuration
  input  wire op_mode_t mode,
  input  wire clk_cfg_t cfg,
  // gated clock enables
  output clk_en_t       clk_en_q
);

  clk_en_t clk_en_d;
  logic    run;
  logic    wt;
  logic    sys_on;

  // ****************************************************************
  // enable policy
  // ****************************************************************
  // per-module wait bits only matter while system clocks run in wait
  always_comb begin
    run    = (mode == MODE_RUN);
    wt     = (mode == MODE_WAIT);
    sys_on = run | (wt & ~cfg.system_wait_clock_stop);
    clk_en_d               = '0;  // stop: everything off
    clk_en_d.core          = sys_on;
    clk_en_d.flash         = sys_on;
    clk_en_d.cal_ram       = sys_on;
    clk_en_d.sram          = sys_on;
    clk_en_d.port_int      = sys_on;
    clk_en_d.pulse_mod     = run | (sys_on & ~cfg.pulse_mod_wait_stop);
    clk_en_d.capture_timer = run | (sys_on & ~cfg.capture_timer_wait_stop);
    clk_en_d.converter     = run | (sys_on & ~cfg.converter_wait_stop);
    clk_en_d.serial_periph = cfg.serial_periph_run_en
                           & (run | (sys_on & ~cfg.serial_periph_wait_stop));
    clk_en_d.async_serial  = run | (sys_on & ~cfg.async_serial_wait_stop);
    // voltage monitor never runs in wait
    clk_en_d.volt_monitor  = run & cfg.volt_monitor_en;
  end

  // registered so the gate cells see a glitch-free enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clk_en_q <= '1;
    end else begin
      clk_en_q <= clk_en_d;
    end
  end

endmodule : clk_gate_policy

// >>> testbench/sysconf_bank_assertions.sv
`timescale 1ns/1ps

module sysconf_bank_assertions
  import sysconf_pkg::*;
#(
  parameter logic [3:0] MAJOR_FAMILY = 4'h1,
  parameter logic [3:0] MINOR_FAMILY = 4'h2,
  parameter logic [3:0] MAJOR_REV    = 4'h3,
  parameter logic [3:0] MINOR_REV    = 4'h4
) (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // pins and bus
  input wire logic        ext_reset_n,
  input wire logic [15:0] bus_addr,
  input wire logic        bus_rd,
  input wire logic        bus_wr,
  input wire logic [7:0]  bus_wdata,
  input wire logic        bus_hit,
  input wire logic [7:0]  bus_rdata_q,
  // mode, pads and clocks
  input wire op_mode_t    mode,
  input wire clk_cfg_t    clk_cfg,
  input wire pad_ctl_t    pad_ctl_q,
  input wire logic [4:0]  regblock_base_q,
  input wire clk_en_t     clk_en_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ****
  // decode helpers
  // ****
  logic       blk;
  logic       rdb;
  logic       wrb;
  logic [9:0] ofs;
  // block match requires bit 10 low, so the upper 1K of each 2K slot stays silent
  assign blk = (bus_addr[15:11] == regblock_base_q) && !bus_addr[10];
  assign rdb = bus_rd && blk;
  assign wrb = bus_wr && blk;
  assign ofs = bus_addr[9:0];

  // ****
  // checks
  // ****
  a_ident_high: assert property (rdb && ofs == OFS_IDENT_HIGH
    |=> bus_rdata_q == {MAJOR_FAMILY, MINOR_FAMILY}) else $error("ident high wrong");
  a_ident_low: assert property (rdb && ofs == OFS_IDENT_LOW
    |=> bus_rdata_q == {MAJOR_REV, MINOR_REV}) else $error("ident low wrong");
  a_size_zero: assert property (rdb && ofs == OFS_MEMSIZE_0
    |=> bus_rdata_q == 8'h10) else $error("size 0 wrong");
  a_size_one: assert property (rdb && ofs == OFS_MEMSIZE_1
    |=> bus_rdata_q == 8'hc3) else $error("size 1 wrong");
  a_pull_write: assert property (wrb && ofs == OFS_PULL_ENABLE |=>
    pad_ctl_q.pullup_en == {$past(bus_wdata[7]), $past(bus_wdata[4]),
    $past(bus_wdata[1]), $past(bus_wdata[0])}) else $error("pull map wrong");
  a_base_write: assert property (wrb && ofs == OFS_BASE_INIT
    |=> regblock_base_q == {1'b0, $past(bus_wdata[6:3])}) else $error("base wrong");
  a_outside_miss: assert property ((bus_rd || bus_wr) && !blk |-> !bus_hit)
    else $error("hit outside block");
  a_reset_pads: assert property (disable iff (1'b0) rst |=>
    pad_ctl_q.pullup_en == 4'hc && pad_ctl_q.low_drive == 4'h0) else $error("pad reset");
  a_pulldown_follow: assert property (1'b1
    |=> pad_ctl_q.mode_pulldown == !$past(ext_reset_n)) else $error("pulldown wrong");
  a_stop_all_off: assert property (mode == MODE_STOP |=> clk_en_q == '0)
    else $error("clock runs in stop");
  a_syswait_off: assert property (mode == MODE_WAIT && clk_cfg.system_wait_clock_stop
    |=> clk_en_q == '0) else $error("clock runs in system wait");
  a_wait_core_on: assert property (mode == MODE_WAIT && !clk_cfg.system_wait_clock_stop
    |=> clk_en_q[10:6] == 5'h1f && !clk_en_q.volt_monitor) else $error("wait core");
  a_run_optional: assert property (mode == MODE_RUN |=>
    clk_en_q.serial_periph == $past(clk_cfg.serial_periph_run_en)) else $error("run spi");

  // main scenarios reached
  c_ident_read: cover property (rdb && ofs == OFS_IDENT_HIGH);
  c_base_move: cover property (wrb && ofs == OFS_BASE_INIT);
  c_stop_mode: cover property (mode == MODE_STOP);
endmodule : sysconf_bank_assertions

// >>> testbench/sysconf_bank_tb.sv
`timescale 1ns/1ps

bind sysconf_bank sysconf_bank_assertions #(.MAJOR_FAMILY(MAJOR_FAMILY),
  .MINOR_FAMILY(MINOR_FAMILY), .MAJOR_REV(MAJOR_REV), .MINOR_REV(MINOR_REV))
  sysconf_bank_assertions_inst (.clk_sys, .rst, .ext_reset_n, .bus_addr, .bus_rd, .bus_wr,
  .bus_wdata, .bus_hit, .bus_rdata_q, .mode, .clk_cfg, .pad_ctl_q, .regblock_base_q,
  .clk_en_q);

module sysconf_bank_tb
  import sysconf_pkg::*;
;
  logic        clk_sys;
  logic        rst;
  logic        ext_reset_n;
  logic        bus_rd;
  logic        bus_wr;
  logic        bus_hit;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata_q;
  op_mode_t    mode;
  clk_cfg_t    clk_cfg;
  pad_ctl_t    pad_ctl_q;
  logic [4:0]  regblock_base_q;
  clk_en_t     clk_en_q;
  int          errors;
  int          comparisons;

  // identification values are arbitrary
  sysconf_bank #(.MAJOR_FAMILY(4'ha), .MINOR_FAMILY(4'h5), .MAJOR_REV(4'hc),
    .MINOR_REV(4'h9)) sysconf_bank_inst (.clk_sys, .rst, .ext_reset_n, .bus_addr,
    .bus_rd, .bus_wr, .bus_wdata, .bus_hit, .bus_rdata_q, .mode, .clk_cfg, .pad_ctl_q,
    .regblock_base_q, .clk_en_q);

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ****
  // shared tasks
  // ****
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk_v(input string n, input logic [10:0] e, input logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk_v

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // an idle cycle follows each access so no strobe is set twice in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge clk_sys);
    bus_wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
    bus_addr = a;
    bus_rd = 1'b1;
    #1;
    chk("bus hit", {7'h0, h}, {7'h0, bus_hit});
    @(negedge clk_sys);
    bus_rd = 1'b0;
    chk("read data", e, bus_rdata_q);
    @(negedge clk_sys);
  endtask : rd

  // ****
  // scenarios
  // ****
  task automatic do_reset();
    rst = 1'b1;
    ext_reset_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    chk("pulldown on", 8'h1, {7'h0, pad_ctl_q.mode_pulldown});
    chk("pad reset", 8'hc0, {pad_ctl_q.pullup_en, pad_ctl_q.low_drive});
    rst = 1'b0;
    ext_reset_n = 1'b1;
    @(negedge clk_sys);
    chk("pulldown off", 8'h0, {7'h0, pad_ctl_q.mode_pulldown});
    $display("test reset done");
  endtask : do_reset

  task automatic t_pads();
    wr(16'h000c, 8'h82);
    chk("pull map", 8'ha, {4'h0, pad_ctl_q.pullup_en});
    rd(16'h000c, 8'h82, 1'b1);
    wr(16'h000d, 8'hff);
    rd(16'h000d, 8'h93, 1'b1);
    chk("low drive", 8'hf, {4'h0, pad_ctl_q.low_drive});
    $display("test pads done");
  endtask : t_pads

  task automatic t_ident();
    logic [9:0] o[4] = '{OFS_IDENT_HIGH, OFS_IDENT_LOW, OFS_MEMSIZE_0, OFS_MEMSIZE_1};
    logic [7:0] e[4] = '{8'ha5, 8'hc9, 8'h10, 8'hc3};
    for (int i = 0; i < 4; i++) begin
      rd({6'h0, o[i]}, e[i], 1'b1);
      wr({6'h0, o[i]}, ~e[i]);
      rd({6'h0, o[i]}, e[i], 1'b1);
    end
    $display("test ident done");
  endtask : t_ident

  task automatic t_base();
    wr(16'h0011, 8'hff);
    chk("base", 8'h0f, {3'h0, regblock_base_q});
    rd(16'h7811, 8'h78, 1'b1);
    rd(16'h001a, 8'h00, 1'b0);
    rd(16'h7c1a, 8'h00, 1'b0);
    rd(16'h781b, 8'hc9, 1'b1);
    wr(16'h7811, 8'h08);
    rd(16'h081a, 8'ha5, 1'b1);
    rd(16'h080e, 8'h00, 1'b0);
    $display("test base done");
  endtask : t_base

  task automatic t_clk();
    op_mode_t    m[7] = '{MODE_RUN, MODE_RUN, MODE_WAIT, MODE_WAIT, MODE_WAIT, MODE_WAIT,
                          MODE_STOP};
    logic [7:0]  c[7] = '{8'h00, 8'h03, 8'h03, 8'h7f, 8'h41, 8'h80, 8'h03};
    logic [10:0] e[7] = '{11'h7f9, 11'h7ff, 11'h7fd, 11'h7c0, 11'h7d9, 11'h000, 11'h000};
    for (int i = 0; i < 7; i++) begin
      mode = m[i];
      clk_cfg = c[i];
      @(negedge clk_sys);
      chk_v("clock enables", e[i], clk_en_q);
    end
    $display("test clocks done");
  endtask : t_clk

  // main sequence, with a second reset in mid-run
  initial begin
    errors = 0;
    comparisons = 0;
    bus_addr = 16'h0000;
    bus_wdata = 8'h00;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    mode = MODE_RUN;
    clk_cfg = '0;
    do_reset();
    t_pads();
    do_reset();
    rd(16'h000c, 8'h90, 1'b1);
    rd(16'h000d, 8'h00, 1'b1);
    t_ident();
    t_base();
    t_clk();
    wrap_up();
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end
endmodule : sysconf_bank_tb
